/* common/iome_pkg.sv */
/*
  Shared constants and carriers for the increment/OR/move execute block.
  Assumes a 14-bit program word and an 8-bit data path.
*/
package iome_pkg;
  // ===========================================================
  // Word layout
  localparam int WORD_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int DEST_BIT = 7;
  localparam int OP_HI = 13;
  localparam int OP_LO = 8;
  // ===========================================================
  // Opcode patterns (bits 13:8)
  localparam logic [5:0] INCREMENT_REGISTER_OP = 6'h0A;
  localparam logic [5:0] OR_ACC_WITH_REGISTER_OP = 6'h04;
  localparam logic [5:0] MOVE_REGISTER_OP = 6'h08;
  localparam logic [5:0] OR_LITERAL_INTO_ACC_OP = 6'h38;
  // ===========================================================
  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;

  typedef enum logic [2:0] {
    IOME_NONE,
    IOME_INC,
    IOME_ORL,
    IOME_ORF,
    IOME_MOV
  } iome_op_e;

  // Decoded instruction
  typedef struct packed {
    iome_op_e op;
    logic dest_file;
    logic [6:0] addr;
    logic [7:0] literal;
  } iome_dec_s;

  // File register write request
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } iome_wr_s;
endpackage

/* hw/iome_decode.sv */
/*
  Combinational decoder for the four supported instruction words.
  Assumes the word is stable for the whole instruction cycle.
*/
`timescale 1ns/100ps
module iome_decode (
  input wire logic [13:0] word_i, // Instruction word
  output iome_pkg::iome_dec_s dec_o // Decoded fields
);
  // ===========================================================
  // Opcode match and field extraction
  always_comb
  begin
    dec_o.dest_file = word_i[iome_pkg::DEST_BIT];
    dec_o.addr = word_i[6:0];
    dec_o.literal = word_i[7:0];
    case (word_i[iome_pkg::OP_HI:iome_pkg::OP_LO])
      iome_pkg::INCREMENT_REGISTER_OP: dec_o.op = iome_pkg::IOME_INC;
      iome_pkg::OR_LITERAL_INTO_ACC_OP: dec_o.op = iome_pkg::IOME_ORL;
      iome_pkg::OR_ACC_WITH_REGISTER_OP: dec_o.op = iome_pkg::IOME_ORF;
      iome_pkg::MOVE_REGISTER_OP: dec_o.op = iome_pkg::IOME_MOV;
      default: dec_o.op = iome_pkg::IOME_NONE;
    endcase
  end
endmodule

/* hw/iome_execute.sv */
/*
  Executes increment, OR-literal, OR-register and move-register words.
  Assumes fetch supplies one valid word per cycle and the register file
  answers the read address combinationally in the same cycle.
*/
// What this block does
// (RULE_01) Increment adds one to a file register modulo 256, sets zero.
// (RULE_02) Increment result goes to accumulator if dest clear, else register.
// (RULE_03) OR-literal ORs accumulator with low eight bits into accumulator.
// (RULE_04) OR-register ORs accumulator with register, routed by dest bit.
// (RULE_05) Move copies the register value unchanged to its destination.
// (RULE_06) Move: dest clear loads accumulator, set rewrites same register.
// (RULE_07) Move updates zero flag even when writing back to itself.
// (RULE_08) One word, one cycle each; zero set exactly when result is zero.
`timescale 1ns/100ps
module iome_execute (
  input wire logic clk_i, // 10 MHz core clock
  input wire logic reset_i, // Async reset, active high
  input wire logic valid_i, // Instruction word valid
  input wire logic [13:0] word_i, // Instruction word
  output logic [6:0] rd_addr_o, // File register read address
  input wire logic [7:0] rd_data_i, // File register read data
  output iome_pkg::iome_wr_s wr_o, // File register write
  output logic [7:0] acc_o, // Working accumulator
  output logic zero_o, // Zero flag
  output logic done_o // Supported word executed
);
  iome_pkg::iome_dec_s dec;
  logic [7:0] acc;
  logic zero;
  iome_pkg::iome_wr_s wr;
  logic done;
  logic [7:0] next_acc;
  logic next_zero;
  iome_pkg::iome_wr_s next_wr;
  logic next_done;
  logic [7:0] result;
  logic hit;
  logic [7:0] operand;

  // ===========================================================
  // Decoder
  iome_decode u_decode (
    .word_i(word_i),
    .dec_o(dec)
  );

  assign rd_addr_o = dec.addr;

  // Zero test shared by every result path
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  // ===========================================================
  // Operand bypass
  // The file write lands one edge after the result is registered, so a
  // word that reads the same register in the very next cycle would see
  // the stale value; the pending write-back data is used instead.
  always_comb
  begin
    operand = rd_data_i;
    if (wr.we && (wr.addr == dec.addr))
      operand = wr.data;
  end

  // ===========================================================
  // Execute: result, destination and flag
  always_comb
  begin
    next_acc = acc;
    next_zero = zero;
    next_wr = '0;
    next_done = 1'b0;
    hit = valid_i && (dec.op != iome_pkg::IOME_NONE);
    case (dec.op)
      iome_pkg::IOME_INC: result = operand + 8'h01; // RULE_01
      iome_pkg::IOME_ORL: result = acc | dec.literal; // RULE_03
      iome_pkg::IOME_ORF: result = acc | operand; // RULE_04
      iome_pkg::IOME_MOV: result = operand; // RULE_05
      default: result = acc;
    endcase
    if (hit)
    begin
      next_done = 1'b1; // RULE_08
      next_zero = is_zero(result); // RULE_07
      if (dec.op == iome_pkg::IOME_ORL)
        next_acc = result; // RULE_03
      else if (dec.dest_file)
      begin
        // Write back to the addressed register
        next_wr.we = 1'b1; // RULE_02 RULE_06
        next_wr.addr = dec.addr;
        next_wr.data = result;
      end
      else
        next_acc = result; // RULE_02
    end
  end

  // Register state
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      acc <= iome_pkg::ACC_RESET;
      zero <= iome_pkg::ZERO_RESET;
      wr <= '0;
      done <= 1'b0;
    end
    else
    begin
      acc <= next_acc;
      zero <= next_zero;
      wr <= next_wr;
      done <= next_done;
    end
  end

  assign acc_o = acc;
  assign zero_o = zero;
  assign wr_o = wr;
  assign done_o = done;

  // ===========================================================
  // Assertions
  // All checks run on the core clock and sleep while reset is high
  default clocking core_cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // Increment into the accumulator wraps from FF to 00
  a_inc_wraps: assert property ( // RULE_01
    valid_i && dec.op == iome_pkg::IOME_INC && !dec.dest_file
    |=> acc_o == $past(operand) + 8'h01)
    else $error("increment result wrong");

  // Increment sets zero only when the operand was FF
  a_inc_zero: assert property ( // RULE_01
    valid_i && dec.op == iome_pkg::IOME_INC
    |=> zero_o == ($past(operand) == 8'hFF))
    else $error("increment zero flag wrong");

  // Increment with dest set writes the file and spares the accumulator
  a_inc_to_file: assert property ( // RULE_02
    valid_i && dec.op == iome_pkg::IOME_INC && dec.dest_file
    |=> wr_o.we && wr_o.data == $past(operand) + 8'h01 && $stable(acc_o))
    else $error("increment write-back wrong");

  // OR-literal always lands in the accumulator, never in the file
  a_orl_acc: assert property ( // RULE_03
    valid_i && dec.op == iome_pkg::IOME_ORL
    |=> acc_o == ($past(acc_o) | $past(word_i[7:0])) && !wr_o.we)
    else $error("or literal wrong");

  // OR-register with dest clear updates the accumulator only
  a_orf_route: assert property ( // RULE_04
    valid_i && dec.op == iome_pkg::IOME_ORF && !dec.dest_file
    |=> acc_o == ($past(acc_o) | $past(operand)) && !wr_o.we)
    else $error("or register wrong");

  // OR-register with dest set writes the file and keeps the accumulator
  a_orf_file: assert property ( // RULE_04
    valid_i && dec.op == iome_pkg::IOME_ORF && dec.dest_file
    |=> wr_o.we && wr_o.data == ($past(acc_o) | $past(operand))
        && $stable(acc_o))
    else $error("or register write-back wrong");

  // Move with dest clear copies the register into the accumulator
  a_mov_acc: assert property ( // RULE_05
    valid_i && dec.op == iome_pkg::IOME_MOV && !dec.dest_file
    |=> acc_o == $past(operand) && !wr_o.we)
    else $error("move to acc wrong");

  // Move with dest set rewrites the same register with the same value
  a_mov_same_reg: assert property ( // RULE_06
    valid_i && dec.op == iome_pkg::IOME_MOV && dec.dest_file
    |=> wr_o.we && wr_o.addr == $past(word_i[6:0])
        && wr_o.data == $past(operand) && $stable(acc_o))
    else $error("move write-back wrong");

  // Move updates zero from the moved value on either destination
  a_mov_zero: assert property ( // RULE_07
    valid_i && dec.op == iome_pkg::IOME_MOV
    |=> zero_o == ($past(operand) == 8'h00))
    else $error("move zero flag wrong");

  // A taken word gives exactly one done pulse, one cycle later
  a_one_cycle: assert property ( // RULE_08
    valid_i && dec.op != iome_pkg::IOME_NONE
    |=> done_o ##1 (done_o == $past(hit)))
    else $error("not single cycle");

  // Zero follows the 8-bit result wherever it was delivered
  a_zero_exact: assert property ( // RULE_08
    valid_i && dec.op != iome_pkg::IOME_NONE
    |=> zero_o == ((wr_o.we ? wr_o.data : acc_o) == 8'h00))
    else $error("zero flag not from result");

  // No taken word: flag, accumulator and pulses stay quiet
  a_zero_hold: assert property ( // RULE_08
    !(valid_i && dec.op != iome_pkg::IOME_NONE)
    |=> $stable(zero_o) && $stable(acc_o) && !wr_o.we && !done_o)
    else $error("idle changed state");

  // ===========================================================
  // Cover points for the main scenarios
  // Increment of FF that wraps to zero
  c_inc_wrap: cover property (
    valid_i && dec.op == iome_pkg::IOME_INC && operand == 8'hFF);

  // OR-literal taken
  c_orl: cover property (
    valid_i && dec.op == iome_pkg::IOME_ORL);

  // OR-register writing back into the file
  c_orf_file: cover property (
    valid_i && dec.op == iome_pkg::IOME_ORF && dec.dest_file);

  // Move used as a register test
  c_mov_test: cover property (
    valid_i && dec.op == iome_pkg::IOME_MOV && dec.dest_file);

  // Operand taken from a write-back still in flight
  c_bypass: cover property (
    valid_i && wr.we && wr.addr == dec.addr);
endmodule

/* tb/iome_regfile_model.sv */
/*
  Register file model facing the execute block.
  Assumes writes land on the clock edge that sees the request.
*/
`timescale 1ns/100ps
module iome_regfile_model (
  input wire logic clk_i, // Core clock
  input wire logic [6:0] rd_addr_i, // Read address
  output logic [7:0] rd_data_o, // Read data
  input wire iome_pkg::iome_wr_s wr_i // Write request
);
  logic [7:0] mem [128];
  // Read answers in the same cycle
  assign rd_data_o = mem[rd_addr_i];
  // Write request is taken at the edge
  always @(posedge clk_i)
  begin
    if (wr_i.we)
      mem[wr_i.addr] <= wr_i.data;
  end
endmodule

/* tb/increment_or_move_execute_tb_top.sv */
/*
  Self-checking bench for the execute block.
  Assumes the register file model answers reads combinationally.
*/
`timescale 1ns/100ps
module increment_or_move_execute_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic valid = 1'b0;
  logic [13:0] word = 14'h0000;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] acc;
  logic zero;
  logic done;
  iome_pkg::iome_wr_s wr;
  int err_total = 0;
  int samples_checked = 0;
  // Clock of 100 ns
  always #50 clk = ~clk;
  iome_execute u_iome_execute (.clk_i(clk), .reset_i(reset),
    .valid_i(valid), .word_i(word), .rd_addr_o(rd_addr),
    .rd_data_i(rd_data), .wr_o(wr), .acc_o(acc), .zero_o(zero),
    .done_o(done));
  iome_regfile_model u_iome_regfile_model (.clk_i(clk),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .wr_i(wr));
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected done: the opcode field names one of the four words
  function automatic logic known(input logic [13:0] w);
    logic [5:0] op;
    op = w[iome_pkg::OP_HI:iome_pkg::OP_LO];
    known = (op == iome_pkg::INCREMENT_REGISTER_OP)
      || (op == iome_pkg::OR_LITERAL_INTO_ACC_OP)
      || (op == iome_pkg::OR_ACC_WITH_REGISTER_OP)
      || (op == iome_pkg::MOVE_REGISTER_OP);
  endfunction
  // One word, checked one cycle later, pulses gone the cycle after
  task automatic run(input logic [13:0] w, input logic [7:0] ea,
    input logic ez, input logic ew, input logic [7:0] ed);
    @(posedge clk);
    valid <= 1'b1;
    word <= w;
    @(posedge clk);
    valid <= 1'b0;
    #1;
    chk(acc, ea);
    chk({5'h00, zero, wr.we, done}, {5'h00, ez, ew, known(w)});
    if (ew)
    begin
      chk({1'b0, wr.addr}, {1'b0, w[6:0]});
      chk(wr.data, ed);
    end
    @(posedge clk);
    #1;
    chk({6'h00, wr.we, done}, 8'h00);
    if (ew)
      chk(u_iome_regfile_model.mem[w[6:0]], ed);
  endtask
  task automatic t_inc();
    u_iome_regfile_model.mem[5] = 8'hFF;
    u_iome_regfile_model.mem[6] = 8'h41;
    run(14'h0A85, 8'h00, 1'b1, 1'b1, 8'h00);
    run(14'h0A06, 8'h42, 1'b0, 1'b0, 8'h00);
    $display("increment done");
  endtask
  task automatic t_or();
    u_iome_regfile_model.mem[16] = 8'h88;
    run(14'h3835, 8'h77, 1'b0, 1'b0, 8'h00);
    run(14'h0490, 8'h77, 1'b0, 1'b1, 8'hFF);
    run(14'h0410, 8'hFF, 1'b0, 1'b0, 8'h00);
    $display("or done");
  endtask
  task automatic t_mov();
    u_iome_regfile_model.mem[32] = 8'h00;
    u_iome_regfile_model.mem[33] = 8'h5C;
    run(14'h08A0, 8'hFF, 1'b1, 1'b1, 8'h00);
    run(14'h0821, 8'h5C, 1'b0, 1'b0, 8'h00);
    run(14'h3F21, 8'h5C, 1'b0, 1'b0, 8'h00);
    $display("move done");
  endtask
  // Dependent words back to back must see each other's results
  task automatic t_back();
    u_iome_regfile_model.mem[40] = 8'h7E;
    @(posedge clk);
    valid <= 1'b1;
    word <= 14'h0AA8;
    @(posedge clk);
    #1;
    chk(wr.data, 8'h7F);
    @(posedge clk);
    word <= 14'h0828;
    #1;
    chk(wr.data, 8'h80);
    @(posedge clk);
    valid <= 1'b0;
    #1;
    chk(acc, 8'h80);
    chk({6'h00, zero, done}, 8'h01);
    chk(u_iome_regfile_model.mem[40], 8'h80);
    $display("back to back done");
  endtask
  // Reset in mid-run clears the core state, then a zero OR sets the flag
  task automatic t_reset();
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    #1;
    chk(acc, iome_pkg::ACC_RESET);
    chk({5'h00, zero, wr.we, done}, {5'h00, iome_pkg::ZERO_RESET, 2'b00});
    @(posedge clk);
    reset <= 1'b0;
    run(14'h3800, 8'h00, 1'b1, 1'b0, 8'h00);
    $display("reset done");
  endtask
  // A known word without valid must leave everything alone
  task automatic t_idle();
    @(posedge clk);
    word <= 14'h0A85;
    @(posedge clk);
    #1;
    chk(acc, 8'h00);
    chk({5'h00, zero, wr.we, done}, 8'h04);
    $display("idle done");
  endtask
  // Watchdog
  initial
  begin
    #20000;
    err_total++;
    conclude();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk(acc, iome_pkg::ACC_RESET);
    chk({5'h00, zero, wr.we, done}, {5'h00, iome_pkg::ZERO_RESET, 2'b00});
    t_inc();
    t_or();
    t_mov();
    t_back();
    t_reset();
    t_idle();
    conclude();
  end
endmodule
